// ===== verilog/gcp_pkg.sv
// Constants shared by the GPIO command interpreter and its helpers.
// Assumes one 250 MHz clock and a synchronous active-high reset.
`default_nettype none
package gcp_pkg;
   localparam int unsigned GCP_CMD_BYTES = 9;
   localparam int unsigned GCP_REPLY_BYTES = 5;
   localparam logic [3:0] GCP_LAST_CMD_IDX = 4'h8;
   localparam logic [2:0] GCP_LAST_REPLY_IDX = 3'h4;
   localparam logic [7:0] GCP_CMD_GET_FUNC = 8'h10;
   localparam logic [7:0] GCP_CMD_GET_DIR = 8'h11;
   localparam logic [7:0] GCP_CMD_GET_LVL = 8'h12;
   localparam logic [7:0] GCP_CMD_GET_STATE = 8'h13;
   localparam logic [7:0] GCP_CMD_SET_DIR = 8'h19;
   localparam logic [7:0] GCP_CMD_SET_LVL = 8'h1a;
   localparam logic [7:0] GCP_CMD_SET_STATE = 8'h1b;
   localparam logic [7:0] GCP_INVALID_REPLY = 8'hff;
   localparam logic [31:0] GCP_DIR_RESET = 32'h0000_0000;
   localparam logic [31:0] GCP_LVL_RESET = 32'hffff_ffff;
   localparam logic [31:0] GCP_STATE_RESET = 32'h0000_0000;
   localparam logic [31:0] GCP_FUNC_DEFAULT = 32'hffff_ffff;
   // Register byte addresses on the Avalon-MM slave.
   localparam logic [3:0] GCP_ADDR_STATUS = 4'h0;
   localparam logic [3:0] GCP_ADDR_RXDATA = 4'h4;
   localparam logic [3:0] GCP_ADDR_TXDATA = 4'h8;
   localparam logic [3:0] GCP_ADDR_FUNC = 4'hc;
   localparam int unsigned GCP_ST_TXVALID = 0;
   localparam int unsigned GCP_ST_RXREADY = 1;
   typedef enum logic [1:0] {GCP_CMD_GET, GCP_CMD_SET, GCP_CMD_BAD} gcp_class_e;
endpackage
`default_nettype wire

// ===== verilog/gcp_byte_if.sv
// Byte stream carrier between the interpreter and its helpers.
// Assumes a ready/valid handshake on the common clock.
`timescale 1ns/100ps
`default_nettype none
interface gcp_byte_if;
   logic valid;
   logic ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== verilog/gcp_mask_apply.sv
// Masked merge of one pin word, shared by the three set commands.
// Assumes purely combinational use.
`timescale 1ns/100ps
`default_nettype none
module gcp_mask_apply (
   input wire logic [31:0] old_word,
   input wire logic [31:0] mask,
   input wire logic [31:0] new_word,
   output logic [31:0] merged
);
   genvar i;
   generate
      for (i = 0; i < 32; i++) begin : g_bit
         assign merged[i] = mask[i] ? new_word[i] : old_word[i];
      end
   endgenerate
endmodule
`default_nettype wire

// ===== verilog/gcp_avalon_slave.sv
// Avalon-MM slave turning register accesses into byte streams.
// Assumes the master holds a request until waitrequest is low.
`timescale 1ns/100ps
`default_nettype none
module gcp_avalon_slave (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [31:0] func_word,
   output logic [31:0] func_reg_out,
   gcp_byte_if.src cmd,
   gcp_byte_if.snk rsp
);
   logic [31:0] readdata_reg, readdata_next;
   logic ack_reg, ack_next;
   logic [31:0] func_reg, func_next;
   logic [7:0] rx_reg, rx_next;
   logic rx_valid_reg, rx_valid_next;
   logic req;
   assign req = read | write;
   // One wait cycle per access, then the answer at the next edge.
   assign waitrequest = req & ~ack_reg;
   assign readdata = readdata_reg;
   assign func_reg_out = func_reg;
   // A write lands only in the cycle in which waitrequest is low.
   assign cmd.valid = write & ack_reg & (address == gcp_pkg::GCP_ADDR_TXDATA);
   assign cmd.data = writedata[7:0];
   assign rsp.ready = ~rx_valid_reg;
   always_comb begin
      ack_next = req & ~ack_reg;
      readdata_next = readdata_reg;
      func_next = func_reg;
      rx_next = rx_reg;
      rx_valid_next = rx_valid_reg;
      if (read && !ack_reg) begin
         unique case (address)
            gcp_pkg::GCP_ADDR_STATUS: begin
               readdata_next = 32'h0000_0000;
               readdata_next[gcp_pkg::GCP_ST_TXVALID] = rx_valid_reg;
               readdata_next[gcp_pkg::GCP_ST_RXREADY] = cmd.ready;
            end
            gcp_pkg::GCP_ADDR_RXDATA: begin
               readdata_next = {24'h00_0000, rx_reg};
               rx_valid_next = 1'b0;
            end
            gcp_pkg::GCP_ADDR_FUNC: readdata_next = func_reg;
            default: readdata_next = 32'h0000_0000;
         endcase
      end
      if (write && ack_reg && address == gcp_pkg::GCP_ADDR_FUNC) begin
         func_next = writedata;
      end
      // A new reply byte wins over a pop in the same cycle, so none is lost.
      if (rsp.valid && !rx_valid_reg) begin
         rx_next = rsp.data;
         rx_valid_next = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         readdata_reg <= 32'h0000_0000;
         ack_reg <= 1'b0;
         func_reg <= gcp_pkg::GCP_FUNC_DEFAULT;
         rx_reg <= 8'h00;
         rx_valid_reg <= 1'b0;
      end else begin
         readdata_reg <= readdata_next;
         ack_reg <= ack_next;
         func_reg <= func_next;
         rx_reg <= rx_next;
         rx_valid_reg <= rx_valid_next;
      end
   end
   logic unused_func;
   assign unused_func = ^func_word;
endmodule
`default_nettype wire

// ===== verilog/gcp_top.sv
// GPIO command interpreter: takes nine-byte commands, answers them.
// Assumes software moves the bytes over Avalon-MM, one byte per access.
`timescale 1ns/100ps
`default_nettype none
module gcp_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [31:0] gpio_dir,
   output logic [31:0] gpio_active_low,
   output logic [31:0] gpio_state
);
   typedef enum {GCP_S_RECV, GCP_S_EXEC, GCP_S_SEND} gcp_state_e;
   gcp_byte_if cmd_if ();
   gcp_byte_if rsp_if ();
   logic [31:0] func_word;
   gcp_state_e st_reg, st_next;
   logic [3:0] idx_reg, idx_next;
   logic [2:0] oidx_reg, oidx_next;
   logic [7:0] op_reg, op_next;
   logic [31:0] mask_reg, mask_next, val_reg, val_next, reply_reg, reply_next;
   logic [31:0] dir_reg, dir_next, lvl_reg, lvl_next, sta_reg, sta_next;
   logic [31:0] merge_old, merged;
   logic bad_reg, bad_next;

   function automatic gcp_pkg::gcp_class_e gcp_classify(input logic [7:0] op);
      unique case (op)
         gcp_pkg::GCP_CMD_GET_FUNC, gcp_pkg::GCP_CMD_GET_DIR,
         gcp_pkg::GCP_CMD_GET_LVL, gcp_pkg::GCP_CMD_GET_STATE: gcp_classify = gcp_pkg::GCP_CMD_GET;
         gcp_pkg::GCP_CMD_SET_DIR, gcp_pkg::GCP_CMD_SET_LVL,
         gcp_pkg::GCP_CMD_SET_STATE: gcp_classify = gcp_pkg::GCP_CMD_SET;
         default: gcp_classify = gcp_pkg::GCP_CMD_BAD;
      endcase
   endfunction

   gcp_avalon_slave u_bus (
      .clk(clk),
      .reset(reset),
      .address(avs_address),
      .read(avs_read),
      .write(avs_write),
      .writedata(avs_writedata),
      .readdata(avs_readdata),
      .waitrequest(avs_waitrequest),
      .func_word(32'h0000_0000),
      .func_reg_out(func_word),
      .cmd(cmd_if),
      .rsp(rsp_if)
   );

   always_comb begin
      unique case (op_reg)
         gcp_pkg::GCP_CMD_SET_DIR: merge_old = dir_reg;
         gcp_pkg::GCP_CMD_SET_LVL: merge_old = lvl_reg;
         default: merge_old = sta_reg;
      endcase
   end

   gcp_mask_apply u_merge (
      .old_word(merge_old),
      .mask(mask_reg),
      .new_word(val_reg),
      .merged(merged)
   );

   assign cmd_if.ready = (st_reg == GCP_S_RECV);
   assign rsp_if.valid = (st_reg == GCP_S_SEND);
   assign gpio_dir = dir_reg;
   assign gpio_active_low = lvl_reg;
   assign gpio_state = sta_reg;

   always_comb begin
      rsp_if.data = op_reg;
      if (bad_reg) begin
         rsp_if.data = gcp_pkg::GCP_INVALID_REPLY;
      end else if (oidx_reg != 3'h0) begin
         rsp_if.data = reply_reg[8 * (oidx_reg - 3'h1) +: 8];
      end
   end

   always_comb begin
      st_next = st_reg;
      idx_next = idx_reg;
      oidx_next = oidx_reg;
      op_next = op_reg;
      mask_next = mask_reg;
      val_next = val_reg;
      reply_next = reply_reg;
      dir_next = dir_reg;
      lvl_next = lvl_reg;
      sta_next = sta_reg;
      bad_next = bad_reg;
      unique case (st_reg)
         GCP_S_RECV: begin
            if (cmd_if.valid) begin
               if (idx_reg == 4'h0) begin
                  op_next = cmd_if.data;
               end else if (idx_reg < 4'h5) begin
                  mask_next[8 * (idx_reg - 4'h1) +: 8] = cmd_if.data;
               end else begin
                  val_next[8 * (idx_reg - 4'h5) +: 8] = cmd_if.data;
               end
               if (idx_reg == gcp_pkg::GCP_LAST_CMD_IDX) begin
                  idx_next = 4'h0;
                  st_next = GCP_S_EXEC;
               end else begin
                  idx_next = idx_reg + 4'h1;
               end
            end
         end
         GCP_S_EXEC: begin
            bad_next = (gcp_classify(op_reg) == gcp_pkg::GCP_CMD_BAD);
            oidx_next = 3'h0;
            st_next = GCP_S_SEND;
            unique case (op_reg)
               gcp_pkg::GCP_CMD_GET_FUNC: reply_next = func_word;
               gcp_pkg::GCP_CMD_GET_DIR: reply_next = dir_reg;
               gcp_pkg::GCP_CMD_GET_LVL: reply_next = lvl_reg;
               gcp_pkg::GCP_CMD_GET_STATE: reply_next = sta_reg;
               gcp_pkg::GCP_CMD_SET_DIR: begin
                  dir_next = merged;
                  reply_next = merged;
               end
               gcp_pkg::GCP_CMD_SET_LVL: begin
                  lvl_next = merged;
                  reply_next = merged;
               end
               gcp_pkg::GCP_CMD_SET_STATE: begin
                  sta_next = merged;
                  reply_next = merged;
               end
               default: reply_next = reply_reg;
            endcase
         end
         GCP_S_SEND: begin
            if (rsp_if.ready) begin
               if (bad_reg || oidx_reg == gcp_pkg::GCP_LAST_REPLY_IDX) begin
                  st_next = GCP_S_RECV;
                  oidx_next = 3'h0;
               end else begin
                  oidx_next = oidx_reg + 3'h1;
               end
            end
         end
         default: st_next = GCP_S_RECV;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg <= GCP_S_RECV;
         idx_reg <= 4'h0;
         oidx_reg <= 3'h0;
         op_reg <= 8'h00;
         mask_reg <= 32'h0000_0000;
         val_reg <= 32'h0000_0000;
         reply_reg <= 32'h0000_0000;
         dir_reg <= gcp_pkg::GCP_DIR_RESET;
         lvl_reg <= gcp_pkg::GCP_LVL_RESET;
         sta_reg <= gcp_pkg::GCP_STATE_RESET;
         bad_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         idx_reg <= idx_next;
         oidx_reg <= oidx_next;
         op_reg <= op_next;
         mask_reg <= mask_next;
         val_reg <= val_next;
         reply_reg <= reply_next;
         dir_reg <= dir_next;
         lvl_reg <= lvl_next;
         sta_reg <= sta_next;
         bad_reg <= bad_next;
      end
   end
endmodule
`default_nettype wire

// ===== tb/gcp_properties.sv
// Port checker for the GPIO command interpreter.
// Assumes it is bound to gcp_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module gcp_properties (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [31:0] gpio_dir,
   input wire logic [31:0] gpio_active_low,
   input wire logic [31:0] gpio_state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic req;
   logic tx_take;
   assign req = avs_read | avs_write;
   assign tx_take = avs_write & ~avs_waitrequest & (avs_address == gcp_pkg::GCP_ADDR_TXDATA);
   a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
      else $error("waitrequest low in first cycle");
   a_wait_ends: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held too long");
   a_idle_nowait: assert property (!req |-> !avs_waitrequest)
      else $error("waitrequest while idle");
   a_rdata_holds: assert property (!$past(avs_read) |-> $stable(avs_readdata))
      else $error("readdata moved without a read");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest && !(avs_address inside
      {4'h0, 4'h4, 4'h8, 4'hc}) |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   // Pin words may only move just after a command byte, so a stray update is caught.
   a_dir_cause: assert property ($changed(gpio_dir) |-> $past(tx_take, 2) || $past(tx_take)
      || $past(tx_take, 3)) else $error("direction moved without command");
   a_lvl_cause: assert property ($changed(gpio_active_low) |-> $past(tx_take)
      || $past(tx_take, 2) || $past(tx_take, 3)) else $error("level moved without command");
   a_st_cause: assert property ($changed(gpio_state) |-> $past(tx_take)
      || $past(tx_take, 2) || $past(tx_take, 3)) else $error("state moved without command");
   c_state_set: cover property (tx_take ##[1:3] $changed(gpio_state));
   c_dir_set: cover property ($changed(gpio_dir));
   c_bad_reply: cover property (avs_read && !avs_waitrequest && avs_readdata[7:0] == 8'hff);
endmodule
`default_nettype wire

// ===== tb/gcp_host.sv
// Host model: moves command and reply bytes over the register bus.
// Assumes the interpreter register map and one byte per access.
`timescale 1ns/100ps
`default_nettype none
module gcp_host (
   input wire logic clk,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   output var logic [3:0] avs_address,
   output var logic avs_read,
   output var logic avs_write,
   output var logic [31:0] avs_writedata
);
   int tmo = 0;
   initial begin
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~w;
      avs_write <= w;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 64);
      if (n >= 64) tmo++;
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic poll(input int b);
      logic [31:0] s;
      int n;
      n = 0;
      do begin
         bus(1'b0, gcp_pkg::GCP_ADDR_STATUS, 32'h0, s);
         n++;
      end while (s[b] !== 1'b1 && n < 32);
      if (n >= 32) tmo++;
   endtask
   task automatic xfer(input logic [71:0] cmd, output logic [39:0] r, output int nr);
      logic [31:0] q;
      r = 40'h0;
      for (int k = 0; k < 9; k++) begin
         poll(gcp_pkg::GCP_ST_RXREADY);
         bus(1'b1, gcp_pkg::GCP_ADDR_TXDATA, {24'h0, cmd[8*k+:8]}, q);
      end
      nr = 5;
      for (int k = 0; k < nr; k++) begin
         poll(gcp_pkg::GCP_ST_TXVALID);
         bus(1'b0, gcp_pkg::GCP_ADDR_RXDATA, 32'h0, q);
         r[8*k+:8] = q[7:0];
         if (k == 0 && q[7:0] == 8'hff) nr = 1;
      end
   endtask
endmodule
`default_nettype wire

// ===== tb/tb_gcp_top.sv
// Self-checking bench for the GPIO command interpreter.
// Assumes gcp_host drives the bus; models here predict every reply.
`timescale 1ns/100ps
`default_nettype none
module tb_gcp_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [31:0] gpio_dir;
   logic [31:0] gpio_active_low;
   logic [31:0] gpio_state;
   logic [31:0] dir_m, lvl_m, st_m, func_m;
   logic [7:0] ops [9] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h19, 8'h1a, 8'h1b, 8'h00, 8'h55};
   int fail_count = 0;
   int checks = 0;
   initial forever #2 clk = ~clk;
   gcp_top dut_u (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .gpio_dir(gpio_dir),
      .gpio_active_low(gpio_active_low), .gpio_state(gpio_state));
   gcp_host host_u (.clk(clk), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata));
   task automatic check(input logic [95:0] seen, input logic [95:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   function automatic logic [39:0] predict(logic [7:0] c, logic [31:0] m, logic [31:0] v);
      if (c == 8'h19) dir_m = (dir_m & ~m) | (v & m);
      if (c == 8'h1a) lvl_m = (lvl_m & ~m) | (v & m);
      if (c == 8'h1b) st_m = (st_m & ~m) | (v & m);
      case (c)
         8'h10: return {func_m, c};
         8'h11, 8'h19: return {dir_m, c};
         8'h12, 8'h1a: return {lvl_m, c};
         8'h13, 8'h1b: return {st_m, c};
         default: return {32'h0, 8'hff};
      endcase
   endfunction
   task automatic run(input logic [7:0] c, input logic [31:0] m, input logic [31:0] v);
      logic [39:0] r, e;
      logic [31:0] q;
      int nr;
      e = predict(c, m, v);
      host_u.xfer({v, m, c}, r, nr);
      check(96'(nr), (e[7:0] == 8'hff) ? 96'h1 : 96'h5);
      check(96'(r), 96'(e));
      check({gpio_dir, gpio_active_low, gpio_state}, {dir_m, lvl_m, st_m});
      host_u.bus(1'b0, gcp_pkg::GCP_ADDR_STATUS, 32'h0, q);
      check(96'(q[0]), 96'h0);
   endtask
   task automatic do_reset();
      @(posedge clk);
      reset <= 1'b1;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      dir_m = gcp_pkg::GCP_DIR_RESET;
      lvl_m = gcp_pkg::GCP_LVL_RESET;
      st_m = gcp_pkg::GCP_STATE_RESET;
      func_m = gcp_pkg::GCP_FUNC_DEFAULT;
   endtask
   task automatic wrap_up();
      check(96'(host_u.tmo), 96'h0);
      $display("Checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      logic [31:0] q;
      void'($urandom(7254));
      do_reset();
      run(8'h10, $urandom(), $urandom());
      host_u.bus(1'b0, 4'h2, 32'h0, q);
      check(96'(q), 96'h0);
      func_m = $urandom();
      host_u.bus(1'b1, gcp_pkg::GCP_ADDR_FUNC, func_m, q);
      for (int i = 0; i < 9; i++) run(ops[i], 32'hffff_ffff, $urandom());
      for (int i = 0; i < 9; i++) run(ops[i], 32'h0, 32'hffff_ffff);
      for (int i = 0; i < 40; i++) run(ops[$urandom_range(8)], $urandom(), $urandom());
      do_reset();
      run(8'h13, 32'h0, 32'h0);
      run(8'h10, $urandom(), $urandom());
      wrap_up();
   end
   initial begin
      #200000;
      fail_count++;
      wrap_up();
   end
endmodule
bind gcp_top gcp_properties chk_u (.clk(clk), .reset(reset), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gpio_dir(gpio_dir),
   .gpio_active_low(gpio_active_low), .gpio_state(gpio_state));
`default_nettype wire
